// >>> gpib_decoder_pkg.sv
// Purpose: constants and carriers for the bus address and command decoder
// Assumes: 100 MHz clock, command bytes arrive with attention flag attached
// Notes:   command codes use the low seven data bits, bit 7 is ignored
package gpib_decoder_pkg;

    // clock and timing
    localparam int          CLOCK_MHZ            = 100;
    localparam int          TRIGGER_DEADLINE_US  = 2500;   // 2.5 ms when idle
    localparam int          TRIGGER_DEADLINE_CYC = TRIGGER_DEADLINE_US * CLOCK_MHZ;
    localparam logic [1:0]  SWITCH_SETTLE        = 2'h3;   // cycles before switch load

    // address field layout
    localparam int          ADDR_WIDTH     = 5;
    localparam int          GROUP_LSB      = 5;            // bits 6:5 select the group
    localparam logic [1:0]  GROUP_LISTEN   = 2'h1;         // 0x20..0x3f
    localparam logic [1:0]  GROUP_TALK     = 2'h2;         // 0x40..0x5f
    localparam logic [1:0]  GROUP_SECOND   = 2'h3;         // 0x60..0x7f
    localparam logic [4:0]  ADDR_ALL_ONES  = 5'h1f;        // unlisten / untalk slot

    // command codes
    localparam logic [6:0]  CMD_GO_LOCAL       = 7'h01;
    localparam logic [6:0]  CMD_SEL_CLEAR      = 7'h04;
    localparam logic [6:0]  CMD_GROUP_TRIGGER  = 7'h08;
    localparam logic [6:0]  CMD_LOCAL_LOCKOUT  = 7'h11;
    localparam logic [6:0]  CMD_DEVICE_CLEAR   = 7'h14;
    localparam logic [6:0]  CMD_POLL_ENABLE    = 7'h18;
    localparam logic [6:0]  CMD_POLL_DISABLE   = 7'h19;
    localparam logic [6:0]  CMD_UNLISTEN       = 7'h3f;
    localparam logic [6:0]  CMD_UNTALK         = 7'h5f;

    // status byte
    localparam logic [7:0]  STATUS_IDLE        = 8'h20;    // ascii space
    localparam int          STATUS_RQS_BIT     = 6;        // data line seven
    localparam logic [3:0]  STATUS_MESSAGE     = 4'h1;     // talk message number
    localparam logic [7:0]  TERMINATOR_DEFAULT = 8'h0a;

    // byte from the acceptor handshake
    typedef struct packed {
        logic [7:0] data;
        logic       atn;
        logic       eoi;
    } bus_byte_type;

    // byte handed to the instrument or to the source handshake
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } data_byte_type;

endpackage : gpib_decoder_pkg

// >>> gpib_address_command_decoder.sv
// Purpose: decode bus addresses and commands, keep remote, poll and status state
// Assumes: byte handshake logic shares this clock; switches and remote enable are pins
// Notes:   one bus byte per rx_strobe; tx_taken pulses when the talker byte is accepted
//
// Behaviour
// - a listen byte 0x20-0x3e matching our address makes us listener
// - unlisten 0x3f stops us accepting data bytes
// - a talk byte 0x40-0x5e matching the same address makes us talker
// - untalk 0x5f stops us transmitting
// - address is five bits, from switches or panel entry
// - after power-on the address comes from the switches
// - the lock switch blocks panel address changes
// - nothing received over the bus can change the address
// - secondary address bytes are ignored and change no addressing
// - universal commands act whether or not we are addressed
// - device clear returns all settings to power-on values
// - in serial poll the talker sends the status byte, bit 6 is service request
// - reading the polled status byte resets it to space and drops the request
// - talk message 1 returns the status byte and clears it likewise
// - serial poll disable returns the talker to normal data
// - local lockout disables keyboard and local key until remote enable drops
// - addressed commands act only while we are listener
// - go to local leaves remote mode
// - selective device clear resets only this device
// - group trigger runs the chosen action, within 2.5 ms when idle
// - own listen address with remote enable asserted enters remote mode
// - remote holds until remote enable drops, go to local, or local key
// - a data byte with end flag gets a terminator; our terminator carries end
`timescale 1ns/1ps

module gpib_address_command_decoder
    import gpib_decoder_pkg::*;
#(
    parameter int           TRIGGER_CYCLES = TRIGGER_DEADLINE_CYC,
    parameter logic [7:0]   TERMINATOR     = TERMINATOR_DEFAULT
) (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  rx_strobe,           // one bus byte accepted
    input  wire bus_byte_type          rx_byte,
    input  wire logic                  remote_enable_pin,   // asserted high
    input  wire logic [ADDR_WIDTH-1:0] switch_address,
    input  wire logic                  switch_panel_lock,
    input  wire logic                  address_entry_key,   // panel entry pulse
    input  wire logic [ADDR_WIDTH-1:0] panel_address,
    input  wire logic                  return_local_key,
    input  wire logic                  instrument_busy,     // programming string running
    input  wire logic [3:0]            trigger_action_code,
    input  wire logic                  service_request,     // pulse: load status
    input  wire logic [7:0]            service_status,
    input  wire logic [3:0]            talk_message,
    input  wire data_byte_type         device_tx,
    input  wire logic                  tx_taken,            // talker byte accepted
    output logic [ADDR_WIDTH-1:0]      bus_address,
    output logic                       listener,
    output logic                       talker,
    output logic                       remote,
    output logic                       lockout,
    output logic                       keyboard_enabled,
    output logic                       poll_mode,
    output logic                       srq_out,
    output logic [7:0]                 status_byte,
    output logic                       settings_clear,      // pulse
    output logic                       trigger_start,       // pulse
    output logic [3:0]                 trigger_action,
    output logic                       rx_data_valid,       // pulse
    output data_byte_type              rx_data,
    output data_byte_type              tx_data
);

    // refuse a deadline that the trigger check cannot count
    if (TRIGGER_CYCLES < 1) begin : g_bad_deadline
        $error("TRIGGER_CYCLES must be at least 1");
    end

    // pin synchronisers
    logic [ADDR_WIDTH-1:0] sw_addr_meta;
    logic [ADDR_WIDTH-1:0] sw_addr_sync;
    logic                  lock_meta;
    logic                  lock_sync;
    logic                  ren_meta;
    logic                  ren_sync;
    always_ff @(posedge clock) begin
        sw_addr_meta <= switch_address;
        sw_addr_sync <= sw_addr_meta;
        lock_meta    <= switch_panel_lock;
        lock_sync    <= lock_meta;
        ren_meta     <= remote_enable_pin;
        ren_sync     <= ren_meta;
    end

    // byte decode, addresses and commands only on attention bytes
    logic [6:0] code;
    logic [1:0] group;
    logic       is_cmd;
    logic       is_data;
    logic       my_listen;
    logic       my_talk;
    logic       do_unlisten;
    logic       do_untalk;
    logic       do_other_talk;
    logic       addressed_ok;
    assign code          = rx_byte.data[6:0];
    assign group         = code[GROUP_LSB+1:GROUP_LSB];
    assign is_cmd        = rx_strobe && rx_byte.atn;
    assign is_data       = rx_strobe && !rx_byte.atn;
    assign my_listen     = is_cmd && group == GROUP_LISTEN
                           && code[4:0] != ADDR_ALL_ONES
                           && code[4:0] == bus_address;
    assign my_talk       = is_cmd && group == GROUP_TALK
                           && code[4:0] != ADDR_ALL_ONES
                           && code[4:0] == bus_address;
    assign do_unlisten   = is_cmd && code == CMD_UNLISTEN;
    assign do_untalk     = is_cmd && code == CMD_UNTALK;
    assign do_other_talk = is_cmd && group == GROUP_TALK && !my_talk && !do_untalk;
    assign addressed_ok  = is_cmd && listener;

    // address: switches at power-on, panel entry unless locked or keyboard disabled
    logic [1:0] settle;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            settle      <= SWITCH_SETTLE;
            bus_address <= '0;
        end else if (settle != 2'h0) begin
            settle <= settle - 2'h1;
            if (settle == 2'h1)
                bus_address <= sw_addr_sync;
        end else if (address_entry_key && !lock_sync && keyboard_enabled) begin
            bus_address <= panel_address;
        end
    end

    // listener and talker flags; secondary bytes fall through untouched
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            listener <= 1'b0;
            talker   <= 1'b0;
        end else begin
            if (my_listen)
                listener <= 1'b1;
            else if (do_unlisten)
                listener <= 1'b0;
            if (my_talk)
                talker <= 1'b1;
            else if (do_untalk || do_other_talk)
                talker <= 1'b0;
        end
    end

    // remote and lockout
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            remote  <= 1'b0;
            lockout <= 1'b0;
        end else begin
            if (!ren_sync)
                lockout <= 1'b0;
            else if (is_cmd && code == CMD_LOCAL_LOCKOUT)
                lockout <= 1'b1;
            if (!ren_sync)
                remote <= 1'b0;
            else if (my_listen)
                remote <= 1'b1;
            else if (addressed_ok && code == CMD_GO_LOCAL)
                remote <= 1'b0;
            else if (return_local_key && !lockout)
                remote <= 1'b0;
        end
    end
    assign keyboard_enabled = !remote && !lockout;

    // serial poll mode
    always_ff @(posedge clock) begin
        if (sys_rst)
            poll_mode <= 1'b0;
        else if (is_cmd && code == CMD_POLL_ENABLE)
            poll_mode <= 1'b1;
        else if (is_cmd && code == CMD_POLL_DISABLE)
            poll_mode <= 1'b0;
    end

    // status byte: a new request wins over a read that clears
    logic status_talk;
    logic status_read;
    assign status_talk = talker && (poll_mode || talk_message == STATUS_MESSAGE);
    assign status_read = tx_taken && status_talk;
    always_ff @(posedge clock) begin
        if (sys_rst)
            status_byte <= STATUS_IDLE;
        else if (service_request)
            status_byte <= service_status | (8'h01 << STATUS_RQS_BIT);
        else if (status_read)
            status_byte <= STATUS_IDLE;
    end
    assign srq_out = status_byte[STATUS_RQS_BIT];

    // clear pulse for device clear and selective clear
    always_ff @(posedge clock) begin
        if (sys_rst)
            settings_clear <= 1'b0;
        else
            settings_clear <= (is_cmd && code == CMD_DEVICE_CLEAR)
                              || (addressed_ok && code == CMD_SEL_CLEAR);
    end

    // group trigger waits for the instrument to be idle
    logic get_pending;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            get_pending    <= 1'b0;
            trigger_start  <= 1'b0;
            trigger_action <= 4'h0;
        end else begin
            trigger_start <= get_pending && !instrument_busy;
            if (addressed_ok && code == CMD_GROUP_TRIGGER)
                get_pending <= 1'b1;
            else if (!instrument_busy)
                get_pending <= 1'b0;
            if (get_pending && !instrument_busy)
                trigger_action <= trigger_action_code;
        end
    end

    // idle cycles spent waiting on a trigger, read only by the checks
    logic [31:0] get_wait;
    always_ff @(posedge clock) begin
        if (sys_rst || !get_pending)
            get_wait <= 32'h0;
        else if (!instrument_busy)
            get_wait <= get_wait + 32'h1;
    end

    // listener data with terminator inserted after an end byte
    logic insert_term;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_data_valid <= 1'b0;
            rx_data       <= '0;
            insert_term   <= 1'b0;
        end else begin
            rx_data_valid <= 1'b0;
            insert_term   <= 1'b0;
            if (is_data && listener) begin
                rx_data_valid <= 1'b1;
                rx_data.data  <= rx_byte.data;
                rx_data.last  <= 1'b0;
                insert_term   <= rx_byte.eoi;
            end else if (insert_term) begin
                rx_data_valid <= 1'b1;
                rx_data.data  <= TERMINATOR;
                rx_data.last  <= 1'b1;
            end
        end
    end

    // talker byte: status or instrument data, end flag on final terminator
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_data <= '0;
        end else if (!talker) begin
            tx_data <= '0;
        end else if (status_talk) begin
            tx_data.data <= status_byte;
            tx_data.last <= 1'b0;
        end else begin
            tx_data.data <= device_tx.data;
            tx_data.last <= device_tx.last && device_tx.data == TERMINATOR;
        end
    end

    // checks on addressing
    chk_listen_match: assert property (@(posedge clock) disable iff (sys_rst)
        my_listen |=> listener) else $error("listen address not taken");
    chk_unlisten_drop: assert property (@(posedge clock) disable iff (sys_rst)
        do_unlisten |=> !listener ##1 !rx_data_valid)
        else $error("unlisten did not stop data");
    chk_talk_match: assert property (@(posedge clock) disable iff (sys_rst)
        my_talk |=> talker) else $error("talk address not taken");
    chk_untalk_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        do_untalk |=> !talker ##1 tx_data == '0) else $error("still talking");
    chk_tx_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !talker |=> tx_data == '0)
        else $error("talker byte shown while not talker");
    chk_addr_stable: assert property (@(posedge clock) disable iff (sys_rst)
        (settle == 2'h0 && !address_entry_key) |=> $stable(bus_address))
        else $error("address changed without entry");
    chk_lock_blocks: assert property (@(posedge clock) disable iff (sys_rst)
        (settle == 2'h0 && lock_sync) |=> $stable(bus_address))
        else $error("locked address changed");
    chk_secondary_ign: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && group == GROUP_SECOND) |=> $stable(listener) && $stable(talker))
        else $error("secondary changed addressing");

    // checks on command effects
    chk_clear_pulse: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && code == CMD_DEVICE_CLEAR) |=> settings_clear)
        else $error("device clear missed");
    chk_sel_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (addressed_ok && code == CMD_SEL_CLEAR) |=> settings_clear)
        else $error("selective clear missed");
    chk_poll_enter: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && code == CMD_POLL_ENABLE) |=> poll_mode)
        else $error("poll enable missed");
    chk_poll_byte: assert property (@(posedge clock) disable iff (sys_rst)
        (talker && poll_mode && !tx_taken && !service_request)
        |=> tx_data.data == $past(status_byte)) else $error("poll byte wrong");
    chk_poll_reset: assert property (@(posedge clock) disable iff (sys_rst)
        (status_read && !service_request) |=> status_byte == STATUS_IDLE && !srq_out)
        else $error("status not reset after read");
    chk_poll_leave: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && code == CMD_POLL_DISABLE) |=> !poll_mode)
        else $error("poll disable missed");
    chk_addressed_only: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && !listener && code == CMD_SEL_CLEAR) |=> !settings_clear)
        else $error("unaddressed clear acted");
    chk_gtl_local: assert property (@(posedge clock) disable iff (sys_rst)
        (addressed_ok && code == CMD_GO_LOCAL) |=> !remote)
        else $error("go to local missed");
    chk_trigger_fire: assert property (@(posedge clock) disable iff (sys_rst)
        (get_pending && !instrument_busy) |=> trigger_start)
        else $error("idle trigger not started");
    chk_trigger_time: assert property (@(posedge clock) disable iff (sys_rst)
        get_wait <= TRIGGER_CYCLES) else $error("trigger later than deadline");
    chk_remote_enter: assert property (@(posedge clock) disable iff (sys_rst)
        (my_listen && ren_sync) |=> remote) else $error("remote not entered");
    chk_lockout_set: assert property (@(posedge clock) disable iff (sys_rst)
        (is_cmd && code == CMD_LOCAL_LOCKOUT && ren_sync) |=> lockout)
        else $error("local lockout missed");
    chk_lockout_key: assert property (@(posedge clock) disable iff (sys_rst)
        (lockout && remote && ren_sync && !is_cmd) |=> remote)
        else $error("local key worked in lockout");
    chk_end_term: assert property (@(posedge clock) disable iff (sys_rst)
        (is_data && listener && rx_byte.eoi)
        |=> rx_data_valid ##1 rx_data_valid && rx_data.data == TERMINATOR)
        else $error("terminator not inserted");

    // scenarios worth seeing
    cov_panel_entry: cover property (@(posedge clock) disable iff (sys_rst)
        settle == 2'h0 && address_entry_key && !lock_sync && keyboard_enabled);
    cov_serial_poll: cover property (@(posedge clock) disable iff (sys_rst)
        poll_mode && status_read);
    cov_trigger: cover property (@(posedge clock) disable iff (sys_rst)
        get_pending ##[1:20] trigger_start);
    cov_lockout: cover property (@(posedge clock) disable iff (sys_rst)
        lockout && remote);
    cov_end_byte: cover property (@(posedge clock) disable iff (sys_rst)
        insert_term);

endmodule : gpib_address_command_decoder

// >>> gpib_controller_model.sv
// Purpose: active bus controller model driving bytes, remote enable and talker accept
// Assumes: byte handshake already done; one byte per strobe, same clock as the decoder
// Notes:   drives after the falling edge; released data lines toggle every cycle
`timescale 1ns/1ps

module gpib_controller_model
    import gpib_decoder_pkg::*;
(
    input  wire logic    clock,
    output logic         rx_strobe,
    output bus_byte_type rx_byte,
    output logic         ren,
    output logic         tx_taken
);
    bus_byte_type held;
    logic [9:0]   idle_pat;

    // a released bus shows a changing pattern, not a held copy of the last byte
    assign rx_byte = rx_strobe ? held : bus_byte_type'(idle_pat);

    initial begin
        rx_strobe = 1'b0;
        tx_taken  = 1'b0;
        ren       = 1'b0;
        held      = '0;
        idle_pat  = 10'h155;
    end

    // idle pattern flips each cycle
    always @(negedge clock) begin
        idle_pat <= ~idle_pat;
    end

    // one byte; only the controller sets attention; an end byte leaves a free cycle
    task automatic send(input logic [7:0] b, input logic atn, input logic eoi, input int gap);
        @(negedge clock);
        held      = '{data: b, atn: atn, eoi: eoi};
        rx_strobe = 1'b1;
        @(negedge clock);
        rx_strobe = 1'b0;
        repeat ((eoi && !atn && gap < 1) ? 1 : gap) @(negedge clock);
    endtask : send

    // remote enable level; local returns the keyboard
    task automatic set_ren(input logic v);
        @(negedge clock);
        ren = v;
        repeat (5) @(negedge clock);
    endtask : set_ren

    // the bus accepts the current talker byte
    task automatic take();
        @(negedge clock);
        tx_taken = 1'b1;
        @(negedge clock);
        tx_taken = 1'b0;
        repeat (2) @(negedge clock);
    endtask : take
endmodule : gpib_controller_model

// >>> gpib_address_command_decoder_tb_top.sv
// Purpose: self-checking bench for the address and command decoder
// Assumes: controller model supplies bus bytes; pins driven at the falling edge
// Notes:   pulses are counted every rising edge so answers need no exact cycle
`timescale 1ns/1ps

module gpib_address_command_decoder_tb_top;
    import gpib_decoder_pkg::*;
    localparam logic [4:0] SW_ADDR = 5'h09;
    localparam logic [4:0] PANEL   = 5'h03;
    logic clock, sys_rst, strobe, ren, taken, lock, key, lkey, busy, sreq;
    logic [4:0] sw, bus_address;
    logic [7:0] sstat, status_byte;
    logic [3:0] talk_msg, trigger_action, trig_code;
    logic listener, talker, remote, lockout, kb_en, poll_mode, srq_out, clr, trig, rx_v;
    bus_byte_type  rx_b;
    data_byte_type dev_tx, rx_data, tx_data;
    data_byte_type rx_seen[$];
    int num_errors = 0, num_checks = 0, clr_cnt = 0, trig_cnt = 0, cycles = 0;

    gpib_controller_model ctl (.clock(clock), .rx_strobe(strobe), .rx_byte(rx_b),
        .ren(ren), .tx_taken(taken));

    gpib_address_command_decoder #(.TRIGGER_CYCLES(50)) dut (.clock(clock),
        .sys_rst(sys_rst), .rx_strobe(strobe), .rx_byte(rx_b), .remote_enable_pin(ren),
        .switch_address(sw), .switch_panel_lock(lock), .address_entry_key(key),
        .panel_address(PANEL), .return_local_key(lkey), .instrument_busy(busy),
        .trigger_action_code(trig_code), .service_request(sreq), .service_status(sstat),
        .talk_message(talk_msg), .device_tx(dev_tx), .tx_taken(taken),
        .bus_address(bus_address), .listener(listener), .talker(talker), .remote(remote),
        .lockout(lockout), .keyboard_enabled(kb_en), .poll_mode(poll_mode),
        .srq_out(srq_out), .status_byte(status_byte), .settings_clear(clr),
        .trigger_start(trig), .trigger_action(trigger_action), .rx_data_valid(rx_v),
        .rx_data(rx_data), .tx_data(tx_data));

    // clock at 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // count pulses, collect listener data, cut a hang short
    always @(posedge clock) begin
        if (clr === 1'b1) clr_cnt++;
        if (trig === 1'b1) trig_cnt++;
        if (rx_v === 1'b1) rx_seen.push_back(rx_data);
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_cnt(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        repeat (4) @(negedge clock);
    endtask : pulse

    task automatic cmd(input logic [7:0] b);
        ctl.send(b, 1'b1, 1'b0, 3);
    endtask : cmd

    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        sys_rst = 1'b1; sw = SW_ADDR; lock = 1'b1; key = 1'b0; lkey = 1'b0;
        busy = 1'b0; sreq = 1'b0; sstat = 8'h00; talk_msg = 4'h0;
        trig_code = 4'h6;
        dev_tx = '{data: 8'h33, last: 1'b0};
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (6) @(negedge clock);
        check_val("status_byte", 9'h020, status_byte);
        check_val("bus_address", SW_ADDR, bus_address);
        pulse(key);
        check_val("bus_address", SW_ADDR, bus_address);
        lock = 1'b0;
        repeat (4) @(negedge clock);
        pulse(key);
        check_val("bus_address", PANEL, bus_address);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        repeat (6) @(negedge clock);
        check_val("bus_address", SW_ADDR, bus_address);
        // listen, remote, secondary and data
        ctl.set_ren(1'b1);
        cmd(8'h20 | SW_ADDR);
        check_val("listener", 1, listener);
        check_val("remote", 1, remote);
        cmd(8'h60);
        check_val("listener", 1, listener);
        ctl.send(8'h40 | SW_ADDR, 1'b0, 1'b0, 0);
        ctl.send(8'h55, 1'b0, 1'b1, 3);
        check_val("talker", 0, talker);
        check_cnt("rx_count", 3, rx_seen.size());
        check_val("rx_first", {3'h2, SW_ADDR, 1'b0}, rx_seen[0]);
        check_val("rx_eoi", 9'h0aa, rx_seen[1]);
        check_val("rx_term", 9'h015, rx_seen[2]);
        // addressed clear and trigger
        cmd(8'h04);
        check_cnt("clear_count", 1, clr_cnt);
        cmd(8'h08);
        check_cnt("trigger_count", 1, trig_cnt);
        check_val("trigger_action", 9'h006, trigger_action);
        busy = 1'b1;
        trig_code = 4'h9;
        cmd(8'h08);
        repeat (10) @(negedge clock);
        check_cnt("trigger_count", 1, trig_cnt);
        busy = 1'b0;
        repeat (4) @(negedge clock);
        check_cnt("trigger_count", 2, trig_cnt);
        check_val("trigger_action", 9'h009, trigger_action);
        // lockout, local key, go to local, remote enable
        cmd(8'h11);
        check_val("lockout", 1, lockout);
        pulse(lkey);
        check_val("remote", 1, remote);
        cmd(8'h01);
        check_val("remote", 0, remote);
        ctl.set_ren(1'b0);
        check_val("lockout", 0, lockout);
        ctl.set_ren(1'b1);
        cmd(8'h20 | SW_ADDR);
        pulse(lkey);
        check_val("remote", 0, remote);
        check_val("keyboard_enabled", 1, kb_en);
        // unlisten, then refused and universal commands
        cmd(8'h3f);
        check_val("listener", 0, listener);
        ctl.send(8'h77, 1'b0, 1'b0, 3);
        check_cnt("rx_count", 3, rx_seen.size());
        cmd(8'h04);
        cmd(8'h08);
        check_cnt("clear_count", 1, clr_cnt);
        check_cnt("trigger_count", 2, trig_cnt);
        cmd(8'h14);
        check_cnt("clear_count", 2, clr_cnt);
        // serial poll and status message
        sstat = 8'h05;
        pulse(sreq);
        check_val("srq_out", 1, srq_out);
        cmd(8'h18);
        cmd(8'h40 | SW_ADDR);
        check_val("talker", 1, talker);
        check_val("poll_mode", 1, poll_mode);
        check_val("tx_poll", 9'h08a, tx_data);
        ctl.take();
        check_val("status_byte", 9'h020, status_byte);
        check_val("srq_out", 0, srq_out);
        cmd(8'h19);
        check_val("tx_data", 9'h066, tx_data);
        check_val("poll_mode", 0, poll_mode);
        dev_tx = '{data: 8'h0a, last: 1'b1};
        repeat (2) @(negedge clock);
        check_val("tx_end", 9'h015, tx_data);
        talk_msg = 4'h1;
        sstat = 8'h02;
        pulse(sreq);
        check_val("tx_msg", 9'h084, tx_data);
        ctl.take();
        check_val("status_byte", 9'h020, status_byte);
        check_val("srq_out", 0, srq_out);
        cmd(8'h5f);
        check_val("talker", 0, talker);
        check_val("tx_data", 9'h000, tx_data);
        cmd(8'h40 | SW_ADDR);
        cmd(8'h42);
        check_val("talker", 0, talker);
        check_val("bus_address", SW_ADDR, bus_address);
        end_of_test();
    end
endmodule : gpib_address_command_decoder_tb_top
